// ### design/faric_defines.svh
`ifndef FARIC_DEFINES_SVH
`define FARIC_DEFINES_SVH

// Register word offsets (byte addresses)
`define FARIC_CTRL_OFS      8'h00
`define FARIC_ADDR_OFS      8'h04
`define FARIC_WDATA_OFS     8'h08
`define FARIC_RDATA_OFS     8'h0C
`define FARIC_STAT_OFS      8'h10
`define FARIC_CMD_OFS       8'h14
// Control field positions
`define FARIC_CTRL_WORD_BIT 0
`define FARIC_CTRL_SEL_LSB  1
`define FARIC_CTRL_RST_BIT  4
`define FARIC_CTRL_VPP_BIT  5
`define FARIC_CTRL_RST_VAL  32'h0000_0011
// Command codes in CMD register
`define FARIC_CMD_READ      2'h1
`define FARIC_CMD_WRITE     2'h2
// Bus access timing in ns and derived cycles at 4 ns
`define FARIC_CLK_NS        4
`define FARIC_T_ACC_NS      150
`define FARIC_T_PAGE_NS     25
`define FARIC_T_WP_NS       70
`define FARIC_T_SETUP_NS    20
`define FARIC_T_RWH_NS      150
`define FARIC_T_PLPH_NS     100
`define FARIC_ACC_CYC  ((`FARIC_T_ACC_NS + `FARIC_CLK_NS - 1) / `FARIC_CLK_NS)
`define FARIC_PAGE_CYC ((`FARIC_T_PAGE_NS + `FARIC_CLK_NS - 1) / `FARIC_CLK_NS)
`define FARIC_WP_CYC   ((`FARIC_T_WP_NS + `FARIC_CLK_NS - 1) / `FARIC_CLK_NS)
`define FARIC_SU_CYC   ((`FARIC_T_SETUP_NS + `FARIC_CLK_NS - 1) / `FARIC_CLK_NS)
`define FARIC_RWH_CYC  ((`FARIC_T_RWH_NS + `FARIC_CLK_NS - 1) / `FARIC_CLK_NS)
`define FARIC_PLPH_CYC ((`FARIC_T_PLPH_NS + `FARIC_CLK_NS - 1) / `FARIC_CLK_NS)

`endif

// ### design/faric_pkg.sv
package faric_pkg;

  // Flash pin bundle driven by the host
  typedef struct packed {
    logic        chip_select_a_n;
    logic        chip_select_b_n;
    logic        chip_select_c;
    logic        read_enable_n;
    logic        write_strobe_n;
    logic        word_mode;
    logic        reset_powerdown_n;
    logic        program_enable_supply;
    logic [23:0] address_inputs;
  } faric_pins_t;

  // Host sequencer states
  typedef enum logic [2:0] {
    FARIC_IDLE   = 3'b000,
    FARIC_RSETUP = 3'b001,
    FARIC_RWAIT  = 3'b010,
    FARIC_WSETUP = 3'b011,
    FARIC_WPULSE = 3'b100,
    FARIC_WHOLD  = 3'b101,
    FARIC_RESET  = 3'b110,
    FARIC_WAKE   = 3'b111
  } faric_state_t;

endpackage : faric_pkg

// ### design/faric_sync.sv
`timescale 1ns/1ns
// Three-stage input synchroniser; output changes when stages two and three agree
module faric_sync
  (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
  );

  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic       q_reg;
  logic       q_next;

  // Shift and agree
  always_comb
  begin
    sh_next = {sh_reg[1:0], d_i};
    q_next  = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : q_reg;
  end

  // Register stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sh_reg <= 3'h7;
      q_reg  <= 1'b1;
    end
    else
    begin
      sh_reg <= sh_next;
      q_reg  <= q_next;
    end
  end

  assign q_o = q_reg;

endmodule : faric_sync

// ### design/faric_host.sv
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ns
// Functional notes
// - Device drives data on reads; host drives data only on writes.
// - Host writes a read command to enter other read modes.
// - For read data, read enable low and write strobe high.
// - Single device host may tie selects b and c low.
// - Host never asserts read enable and write strobe together.
`include "faric_defines.svh"
module faric_host
  #(
    parameter int ADDR_W   = 24,
    parameter int ACC_CYC  = `FARIC_ACC_CYC,
    parameter int PAGE_CYC = `FARIC_PAGE_CYC
  )
  (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic                 wb_we_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    output faric_pkg::faric_pins_t    pins_o,
    output logic [15:0]               data_io_pins_o,
    output logic                      data_io_pins_oe_n_o,
    input  wire logic [15:0]          data_io_pins_i,
    input  wire logic                 ready_busy_output_i
  );

  faric_pkg::faric_state_t st_reg, st_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [23:0] addr_reg, addr_next;
  logic [15:0] wdat_reg, wdat_next;
  logic [15:0] rdat_reg, rdat_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic [20:0] page_reg, page_next;
  logic        page_ok_reg, page_ok_next;
  logic        oe_n_reg, oe_n_next;
  logic        we_n_reg, we_n_next;
  logic        cs_reg, cs_next;
  logic        drv_reg, drv_next;
  logic        done_reg, done_next;
  logic        ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic        rdy_prev_reg, rdy_prev_next;
  logic        cmpl_reg, cmpl_next;
  logic [23:0] adr_pin;
  logic        cmd_ok;
  logic [31:0] rd_mux;
  logic        rdy_sync;
  logic        word_mode;
  logic        bus_req;

  // Busy line crosses in from the pin
  faric_sync u_rdy_sync
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (ready_busy_output_i),
    .q_o   (rdy_sync)
  );

  assign word_mode = ctrl_reg[`FARIC_CTRL_WORD_BIT];
  assign bus_req   = wb_cyc_i && wb_stb_i && !ack_reg;
  assign cmd_ok    = st_reg == faric_pkg::FARIC_IDLE && ctrl_reg[`FARIC_CTRL_RST_BIT];

  // Physical pin address; word mode shifts up, pins past the density stay low
  always_comb
  begin
    adr_pin = word_mode ? {addr_reg[22:0], 1'b0} : addr_reg;
    for (int b = 0; b < 24; b++)
    begin
      if (b >= ADDR_W) adr_pin[b] = 1'b0;
    end
  end

  // Register read mux
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      `FARIC_CTRL_OFS:  rd_mux = ctrl_reg;
      `FARIC_ADDR_OFS:  rd_mux = {8'h00, addr_reg};
      `FARIC_WDATA_OFS: rd_mux = {16'h0000, wdat_reg};
      `FARIC_RDATA_OFS: rd_mux = {16'h0000, rdat_reg};
      `FARIC_STAT_OFS:  rd_mux = {28'h000_0000, cmpl_reg, rdy_sync, done_reg,
                                  st_reg != faric_pkg::FARIC_IDLE};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus slave and access sequencer next state
  always_comb
  begin
    st_next = st_reg; ctrl_next = ctrl_reg; addr_next = addr_reg;
    wdat_next = wdat_reg; rdat_next = rdat_reg; cnt_next = cnt_reg;
    page_next = page_reg; page_ok_next = page_ok_reg;
    oe_n_next = oe_n_reg; we_n_next = we_n_reg; cs_next = cs_reg;
    drv_next = drv_reg; done_next = done_reg; ack_next = 1'b0;
    dat_next = 32'h0000_0000;
    rdy_prev_next = rdy_sync;
    cmpl_next = cmpl_reg;
    if (bus_req)
    begin
      ack_next = 1'b1;
      dat_next = rd_mux; // Read data registered, stands with ack
      if (wb_we_i)
      begin
        unique case (wb_adr_i)
          // Control also taken in power-down so software can wake the device
          `FARIC_CTRL_OFS:
          begin
            if ((st_reg == faric_pkg::FARIC_IDLE || st_reg == faric_pkg::FARIC_RESET) && wb_sel_i[0])
            begin
              ctrl_next    = wb_dat_i;
              page_ok_next = 1'b0; // Width change invalidates the page
            end
          end
          `FARIC_ADDR_OFS:  addr_next = wb_dat_i[23:0];
          `FARIC_WDATA_OFS: wdat_next = wb_dat_i[15:0];
          `FARIC_STAT_OFS:
          begin
            if (wb_dat_i[1]) done_next = 1'b0;
            if (wb_dat_i[3]) cmpl_next = 1'b0;
          end
          `FARIC_CMD_OFS:
          begin
            if (cmd_ok && wb_dat_i[1:0] == `FARIC_CMD_READ)
            begin
              st_next = faric_pkg::FARIC_RSETUP;
              cs_next = 1'b1;
            end
            else if (cmd_ok && wb_dat_i[1:0] == `FARIC_CMD_WRITE)
            begin
              st_next  = faric_pkg::FARIC_WSETUP;
              cs_next  = 1'b1;
              drv_next = 1'b1;
              page_ok_next = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
    unique case (st_reg)
      faric_pkg::FARIC_IDLE:
      begin
        if (!ctrl_reg[`FARIC_CTRL_RST_BIT])
        begin
          st_next = faric_pkg::FARIC_RESET;
          cnt_next = 8'(`FARIC_PLPH_CYC);
          page_ok_next = 1'b0;
        end
      end
      faric_pkg::FARIC_RSETUP:
      begin
        oe_n_next = 1'b0;
        we_n_next = 1'b1;
        // Page hit only needs the short page access time
        cnt_next = (page_ok_reg && page_reg == adr_pin[23:3]) ? 8'(PAGE_CYC) : 8'(ACC_CYC);
        st_next  = faric_pkg::FARIC_RWAIT;
      end
      faric_pkg::FARIC_RWAIT:
      begin
        if (cnt_reg != 8'h00) cnt_next = cnt_reg - 8'h01;
        else
        begin
          rdat_next = word_mode ? data_io_pins_i : {8'h00, data_io_pins_i[7:0]};
          page_next = adr_pin[23:3];
          page_ok_next = 1'b1;
          oe_n_next = 1'b1;
          cs_next   = 1'b0;
          done_next = 1'b1;
          st_next   = faric_pkg::FARIC_IDLE;
        end
      end
      faric_pkg::FARIC_WSETUP:
      begin
        oe_n_next = 1'b1;
        we_n_next = 1'b0;
        cnt_next  = 8'(`FARIC_WP_CYC);
        st_next   = faric_pkg::FARIC_WPULSE;
      end
      faric_pkg::FARIC_WPULSE:
      begin
        if (cnt_reg != 8'h00) cnt_next = cnt_reg - 8'h01;
        else
        begin
          we_n_next = 1'b1;
          cnt_next  = 8'(`FARIC_SU_CYC);
          st_next   = faric_pkg::FARIC_WHOLD;
        end
      end
      faric_pkg::FARIC_WHOLD:
      begin
        if (cnt_reg != 8'h00) cnt_next = cnt_reg - 8'h01;
        else
        begin
          drv_next  = 1'b0;
          cs_next   = 1'b0;
          done_next = 1'b1;
          st_next   = faric_pkg::FARIC_IDLE;
        end
      end
      faric_pkg::FARIC_RESET:
      begin
        if (cnt_reg != 8'h00) cnt_next = cnt_reg - 8'h01;
        else if (ctrl_reg[`FARIC_CTRL_RST_BIT])
        begin
          cnt_next = 8'(`FARIC_RWH_CYC);
          st_next  = faric_pkg::FARIC_WAKE;
        end
      end
      faric_pkg::FARIC_WAKE:
      begin
        if (cnt_reg != 8'h00) cnt_next = cnt_reg - 8'h01;
        else st_next = faric_pkg::FARIC_IDLE;
      end
    endcase
    // Completion edge on the status pin; set wins over a clear
    if (rdy_sync && !rdy_prev_reg) cmpl_next = 1'b1;
  end

  // State registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= faric_pkg::FARIC_IDLE; ctrl_reg <= `FARIC_CTRL_RST_VAL;
      addr_reg <= 24'h00_0000; wdat_reg <= 16'h0000; rdat_reg <= 16'h0000;
      cnt_reg <= 8'h00; page_reg <= 21'h00_0000; page_ok_reg <= 1'b0;
      oe_n_reg <= 1'b1; we_n_reg <= 1'b1; cs_reg <= 1'b0; drv_reg <= 1'b0;
      done_reg <= 1'b0; ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000; rdy_prev_reg <= 1'b1; cmpl_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next; ctrl_reg <= ctrl_next; addr_reg <= addr_next;
      wdat_reg <= wdat_next; rdat_reg <= rdat_next; cnt_reg <= cnt_next;
      page_reg <= page_next; page_ok_reg <= page_ok_next;
      oe_n_reg <= oe_n_next; we_n_reg <= we_n_next; cs_reg <= cs_next;
      drv_reg <= drv_next; done_reg <= done_next; ack_reg <= ack_next;
      dat_reg <= dat_next; rdy_prev_reg <= rdy_prev_next; cmpl_reg <= cmpl_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Pin drive; selects b and c held low for a single device
  always_comb
  begin
    pins_o.chip_select_a_n       = !cs_reg;
    pins_o.chip_select_b_n       = 1'b0;
    pins_o.chip_select_c         = 1'b0;
    pins_o.read_enable_n         = oe_n_reg;
    pins_o.write_strobe_n        = we_n_reg;
    pins_o.word_mode             = word_mode;
    pins_o.reset_powerdown_n     = ctrl_reg[`FARIC_CTRL_RST_BIT] && st_reg != faric_pkg::FARIC_RESET;
    pins_o.program_enable_supply = ctrl_reg[`FARIC_CTRL_VPP_BIT];
    pins_o.address_inputs = adr_pin;
    data_io_pins_o        = word_mode ? wdat_reg : {8'h00, wdat_reg[7:0]};
    data_io_pins_oe_n_o   = !drv_reg;
  end

endmodule : faric_host

// ### dv/faric_host_asserts.sv
`timescale 1ns/1ns
module faric_host_asserts
  (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic                   wb_ack_o,
    input wire faric_pkg::faric_pins_t pins_o,
    input wire logic [15:0]            data_io_pins_o,
    input wire logic                   data_io_pins_oe_n_o
  );
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Write strobe release and bus request steps
  sequence s_wr_end;
    $rose(pins_o.write_strobe_n);
  endsequence
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Bus answer and pin relations
  a_ack_answer: assert property (s_take |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  a_read_no_drive: assert property (!pins_o.read_enable_n |->
    data_io_pins_oe_n_o && pins_o.write_strobe_n) else $error("read overlap");
  a_drive_selected: assert property (!data_io_pins_oe_n_o |-> !pins_o.chip_select_a_n)
    else $error("drive unselected");
  a_strobe_selected: assert property (!pins_o.write_strobe_n |-> !pins_o.chip_select_a_n)
    else $error("strobe unselected");
  a_fixed_selects: assert property (!pins_o.chip_select_b_n && !pins_o.chip_select_c)
    else $error("selects b c");
  a_word_lsb: assert property (pins_o.word_mode |-> !pins_o.address_inputs[0])
    else $error("word lsb");
  a_byte_upper: assert property (!pins_o.word_mode && !data_io_pins_oe_n_o |->
    data_io_pins_o[15:8] == 8'h00) else $error("byte upper");
  a_wr_end_hold: assert property (s_wr_end |-> !data_io_pins_oe_n_o && !pins_o.chip_select_a_n)
    else $error("write hold");
  a_wr_stable: assert property (!pins_o.write_strobe_n && $past(!pins_o.write_strobe_n) |->
    $stable(pins_o.address_inputs) && $stable(data_io_pins_o)) else $error("write moved");
  a_width_stable: assert property (!pins_o.chip_select_a_n && $past(!pins_o.chip_select_a_n) |->
    $stable(pins_o.word_mode)) else $error("width moved");
endmodule : faric_host_asserts

// ### dv/faric_flash_model.sv
`timescale 1ns/1ns
module faric_flash_model
  (
    input  wire faric_pkg::faric_pins_t pins_i,
    input  wire logic [15:0]            dq_i,
    input  wire logic                   dq_oe_n_i,
    output logic [15:0]                 dq_o,
    output logic                        sts_o
  );
  // Only the first bytes of one 128KB erase block are kept
  logic [7:0]  mem [64];
  logic [5:0]  ba;
  logic        sel;
  logic [15:0] din;
  initial foreach (mem[i]) mem[i] = 8'h00;
  initial sts_o = 1'b1;
  // Select decode, ignored in power-down
  assign sel = pins_i.reset_powerdown_n && (pins_i.chip_select_c ?
    !(pins_i.chip_select_a_n && pins_i.chip_select_b_n) : !(pins_i.chip_select_a_n || pins_i.chip_select_b_n));
  // Bit 0 dropped in word mode; upper pins, 22 and 23 too, not decoded
  assign ba = pins_i.word_mode ? {pins_i.address_inputs[5:1], 1'b0} : pins_i.address_inputs[5:0];
  // Read drive, pulled up when released or in byte mode
  assign dq_o = (sel && !pins_i.read_enable_n && pins_i.write_strobe_n) ?
    {pins_i.word_mode ? mem[ba | 6'h01] : 8'hFF, mem[ba]} : 16'hFFFF;
  assign din = dq_oe_n_i ? 16'hFFFF : dq_i;
  // Capture on strobe release, blocked at lockout, busy level meanwhile
  always @(posedge pins_i.write_strobe_n)
    if (sel && pins_i.program_enable_supply)
    begin
      mem[ba] = din[7:0];
      if (pins_i.word_mode)
        mem[ba | 6'h01] = din[15:8];
      sts_o = 1'b0;
      #40 sts_o = 1'b1;
    end
endmodule : faric_flash_model

// ### dv/faric_host_tb.sv
`timescale 1ns/1ns
`include "faric_defines.svh"
module faric_host_tb;
  typedef struct packed {
    logic        wr;
    logic        wm;
    logic [7:0]  ad;
    logic [15:0] dt;
  } faric_row_t;
  logic                   clk_i;
  logic                   rst_i;
  logic [7:0]             wb_adr_i;
  logic [31:0]            wb_dat_i;
  logic [3:0]             wb_sel_i;
  logic                   wb_we_i;
  logic                   wb_cyc_i;
  logic                   wb_stb_i;
  logic [31:0]            wb_dat_o;
  logic                   wb_ack_o;
  faric_pkg::faric_pins_t pins_o;
  logic [15:0]            dq_o;
  logic                   dq_oe_n;
  logic [15:0]            dq_i;
  logic                   sts;
  logic [31:0]            q;
  int                     errors;
  int                     checked;
  faric_row_t             rows [6];
  faric_host DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pins_o(pins_o), .data_io_pins_o(dq_o), .data_io_pins_oe_n_o(dq_oe_n), .data_io_pins_i(dq_i),
    .ready_busy_output_i(sts));
  faric_flash_model u_flash (.pins_i(pins_o), .dq_i(dq_o), .dq_oe_n_i(dq_oe_n), .dq_o(dq_i), .sts_o(sts));
  // Verdict and end of run
  task automatic complete_run;
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // Compare a value against its expectation
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i  <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 64);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      errors++;
      complete_run();
    end
    @(posedge clk_i);
  endtask : wb
  // Poll the busy flag until idle
  task automatic idle;
    int n;
    n = 0;
    do
    begin
      wb(`FARIC_STAT_OFS, 1'b0, 32'h0);
      n++;
    end
    while (q[0] !== 1'b0 && n < 200);
    if (q[0] !== 1'b0)
    begin
      errors++;
      complete_run();
    end
  endtask : idle
  // Mode, address, data, command, then read back the capture
  task automatic op(input faric_row_t r, input logic vpp);
    wb(`FARIC_CTRL_OFS, 1'b1, {26'h0, vpp, 1'b1, 3'h0, r.wm});
    wb(`FARIC_ADDR_OFS, 1'b1, {24'h0, r.ad});
    wb(`FARIC_WDATA_OFS, 1'b1, {16'h0, r.dt});
    wb(`FARIC_CMD_OFS, 1'b1, {30'h0, r.wr ? `FARIC_CMD_WRITE : `FARIC_CMD_READ});
    idle();
    wb(`FARIC_RDATA_OFS, 1'b0, 32'h0);
  endtask : op
  // Bench clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    errors = 0;
    checked = 0;
    rows = '{'{1'b1, 1'b1, 8'h03, 16'h1234}, '{1'b0, 1'b1, 8'h03, 16'h1234}, '{1'b0, 1'b0, 8'h07, 16'h0012},
      '{1'b0, 1'b0, 8'h06, 16'h0034}, '{1'b1, 1'b0, 8'h09, 16'h00A5}, '{1'b0, 1'b1, 8'h04, 16'hA500}};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset pins", 32'h7, {29'h0, pins_o.chip_select_a_n, pins_o.reset_powerdown_n, pins_o.word_mode});
    wb(`FARIC_CTRL_OFS, 1'b0, 32'h0);
    chk("ctrl reset", `FARIC_CTRL_RST_VAL, q);
    wb(8'h20, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    // Table of writes and read-backs in both widths
    foreach (rows[i])
    begin
      op(rows[i], 1'b1);
      if (!rows[i].wr)
        chk("read data", {16'h0, rows[i].dt}, q & (rows[i].wm ? 32'hFFFF : 32'hFF));
    end
    // Earlier writes ended with a completion on the status pin; clear it
    wb(`FARIC_STAT_OFS, 1'b0, 32'h0);
    chk("stat pulse", 32'h8, q & 32'h8);
    wb(`FARIC_STAT_OFS, 1'b1, 32'h8);
    // Lockout blocks the write, reads still work
    op('{1'b1, 1'b1, 8'h03, 16'hBEEF}, 1'b0);
    op('{1'b0, 1'b1, 8'h03, 16'h0000}, 1'b0);
    chk("locked data", 32'h1234, q & 32'hFFFF);
    wb(`FARIC_STAT_OFS, 1'b0, 32'h0);
    chk("stat done", 32'h6, q & 32'hE);
    wb(`FARIC_STAT_OFS, 1'b1, 32'h2);
    wb(`FARIC_STAT_OFS, 1'b0, 32'h0);
    chk("stat clear", 32'h4, q & 32'h6);
    // Power-down and back to array reads
    wb(`FARIC_CTRL_OFS, 1'b1, 32'h21);
    for (int n = 0; n < 40 && pins_o.reset_powerdown_n !== 1'b0; n++)
      @(posedge clk_i);
    chk("powerdown", 32'h0, {31'h0, pins_o.reset_powerdown_n});
    // Wake request is taken while the pin is still held low
    wb(`FARIC_CTRL_OFS, 1'b1, 32'h31);
    idle();
    op('{1'b0, 1'b1, 8'h03, 16'h0000}, 1'b1);
    chk("wake data", 32'h1234, q & 32'hFFFF);
    complete_run();
  end
endmodule : faric_host_tb
bind faric_host faric_host_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .pins_o(pins_o), .data_io_pins_o(data_io_pins_o), .data_io_pins_oe_n_o(data_io_pins_oe_n_o));
